// ### hw/mouse_pkg.sv
package mouse_pkg;

  // ************************************************************
  // Register map (byte addresses on the AXI4-Lite slave)
  // ************************************************************
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_MOTION = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_WHEEL  = 4'hc;

  // Control register fields and reset value
  localparam int         CTRL_USB_BIT  = 0;
  localparam int         CTRL_PS2_BIT  = 1;
  localparam int         CTRL_FIVE_BIT = 2;
  localparam logic [2:0] CTRL_RESET    = 3'h6;

  // Motion register fields
  localparam int MOT_X_LSB  = 0;
  localparam int MOT_XV_BIT = 9;
  localparam int MOT_Y_LSB  = 16;
  localparam int MOT_YV_BIT = 25;

  // Status register fields
  localparam int STS_RES_LSB  = 8;
  localparam int STS_RATE_LSB = 16;
  localparam int STS_MODE_LSB = 24;
  localparam int STS_BUSY_BIT = 26;

  // First status byte bit positions
  localparam int SB_REMOTE = 6;
  localparam int SB_ENABLE = 5;
  localparam int SB_SCALE  = 4;
  localparam int SB_WRAP   = 3;

  // ************************************************************
  // Link command and answer codes
  // ************************************************************
  localparam logic [7:0] CMD_RESET     = 8'hff;
  localparam logic [7:0] CMD_DEFAULTS  = 8'hf6;
  localparam logic [7:0] CMD_DISABLE   = 8'hf5;
  localparam logic [7:0] CMD_ENABLE    = 8'hf4;
  localparam logic [7:0] CMD_SET_RATE  = 8'hf3;
  localparam logic [7:0] CMD_IDENTIFY  = 8'hf2;
  localparam logic [7:0] CMD_REMOTE    = 8'hf0;
  localparam logic [7:0] CMD_WRAP      = 8'hee;
  localparam logic [7:0] CMD_WRAP_EXIT = 8'hec;
  localparam logic [7:0] CMD_READ_DATA = 8'heb;
  localparam logic [7:0] CMD_STREAM    = 8'hea;
  localparam logic [7:0] CMD_STATUS    = 8'he9;
  localparam logic [7:0] CMD_SET_RES   = 8'he8;
  localparam logic [7:0] CMD_SCALE_2   = 8'he7;
  localparam logic [7:0] CMD_SCALE_1   = 8'he6;
  localparam logic [7:0] ANS_ACK       = 8'hfa;
  localparam logic [7:0] ANS_ERROR     = 8'hfc;
  localparam logic [7:0] ANS_PASSED    = 8'haa;
  localparam logic [7:0] ID_STD        = 8'h00;
  localparam logic [7:0] ID_3D         = 8'h03;
  localparam logic [7:0] ID_FIVE       = 8'h04;

  // Mode switch rate sequences
  localparam logic [7:0] RATE_A = 8'hc8;
  localparam logic [7:0] RATE_B = 8'h64;
  localparam logic [7:0] RATE_C = 8'h50;

  // Settings after reset
  localparam logic [7:0] RATE_RESET = 8'h64;
  localparam logic [7:0] RES_RESET  = 8'h02;

  // Transmit queue depth and link frame length
  localparam int         TXQ_DEPTH = 5;
  localparam logic [3:0] FRAME_BITS = 4'd11;

  typedef enum logic [1:0] {MODE_STD, MODE_3D, MODE_FIVE} report_mode_e;
  typedef enum logic [1:0] {ARG_NONE, ARG_RATE, ARG_RES} arg_wait_e;

endpackage : mouse_pkg

// ### hw/mouse_report.sv
// Operation
// - Status byte 1: bit6 remote, bit5 enabled, bit4 scaling 2:1, bit7 reserved.
// - Status byte 1: bit3 wrap active; bits 2..0 left, middle, right.
// - Status bytes 2 and 3 are resolution and sampling rate.
// - Rates C8,64,50 then identify: ack each, answer FA 03, enter 3D.
// - Rates C8,C8,50 then identify: ack each, answer FA 04, enter five-button.
// - Reset command returns to standard three-byte mode.
// - Power-on reset starts in standard mode.
// - Standard packet: overflow, signs, constant 1, buttons; then X and Y.
// - 3D mode adds a fourth byte with eight-bit wheel.
// - X and Y are 9-bit two's complement; wheel 8-bit.
// - Five-button: byte1 bits 7,6 zero; byte4 buttons 5,4 and 4-bit wheel.
// - PS/2: right, up and wheel toward user are positive.
// - Button bits are 1 while held, 0 when released.
// - USB 3D report: byte1 zeros above buttons, then X, Y, wheel.
// - USB five-button report: extra buttons in bits 4 and 3.
// - USB: right, down and wheel away from user are positive.
// - Wheel modes need PS/2 capable part; five-button needs five-button part.
// - Wheel counts divided by two, or four when scale select is high.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
module mouse_report
  import mouse_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ps2_clk_in,
  input  wire logic        ps2_data_in,
  output logic             tx_valid,
  output logic [7:0]       tx_byte,
  input  wire logic        tx_ready,
  input  wire logic        btn_left,
  input  wire logic        btn_middle,
  input  wire logic        btn_right,
  input  wire logic        fourth_button,
  input  wire logic        fifth_button,
  input  wire logic        wheel_phase_a,
  input  wire logic        wheel_phase_b,
  input  wire logic        wheel_scale_select
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [9:0] sync1_r;
  logic [9:0] sync2_r;
  logic       lclk_prev_r;
  logic [1:0] ph_prev_r;

  // Two flops for every asynchronous pin
  always_ff @(posedge aclk) begin
    sync1_r <= {wheel_scale_select, wheel_phase_b, wheel_phase_a, fifth_button,
                fourth_button, btn_right, btn_middle, btn_left, ps2_data_in, ps2_clk_in};
    sync2_r <= sync1_r;
    lclk_prev_r <= sync2_r[0];
    ph_prev_r <= sync2_r[8:7];
  end

  wire       lclk_fall = lclk_prev_r & ~sync2_r[0];
  wire       ldata     = sync2_r[1];
  wire [4:0] btn       = sync2_r[6:2];
  wire       div4      = sync2_r[9];

  // ************************************************************
  // Link receive: start, 8 data, odd parity, stop
  // ************************************************************
  logic [10:0] rx_sh_r;
  logic [3:0]  rx_cnt_r;
  logic        rx_stb_r;

  wire [10:0] rx_sh_nxt = {ldata, rx_sh_r[10:1]};
  wire        rx_full   = lclk_fall && (rx_cnt_r == FRAME_BITS - 4'd1);
  wire        rx_good   = ~rx_sh_nxt[0] & rx_sh_nxt[10] & (^rx_sh_nxt[9:1]);
  wire [7:0]  rx_byte   = rx_sh_r[8:1];

  // Shift on each falling link clock edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sh_r  <= 11'h000;
      rx_cnt_r <= 4'h0;
      rx_stb_r <= 1'b0;
    end else begin
      rx_stb_r <= rx_full & rx_good;
      if (lclk_fall) begin
        rx_sh_r  <= rx_sh_nxt;
        rx_cnt_r <= rx_full ? 4'h0 : rx_cnt_r + 4'h1;
      end
    end
  end

  // ************************************************************
  // Wheel decoder and scaling
  // ************************************************************
  logic signed [9:0] wacc_r;

  wire              ph_step = ^(sync2_r[8:7] ^ ph_prev_r);
  wire              ph_up   = ph_prev_r[0] ^ sync2_r[8];
  wire signed [9:0] wscaled = div4 ? (wacc_r >>> 2) : (wacc_r >>> 1);

  function automatic logic signed [9:0] clamp(input logic signed [9:0] v,
                                              input logic signed [9:0] lim);
    if (v > lim) clamp = lim;
    else if (v < -lim) clamp = -lim;
    else clamp = v;
  endfunction : clamp

  // ************************************************************
  // Settings, mode and control register
  // ************************************************************
  report_mode_e mode_r, mode_nxt;
  arg_wait_e    argw_r, argw_nxt;
  logic       remote_r, remote_nxt, enable_r, enable_nxt;
  logic       scale_r, scale_nxt, wrap_r, wrap_nxt;
  logic [7:0] res_r, res_nxt, rate_r, rate_nxt;
  logic [7:0] hist_r [0:2];
  logic [7:0] hist_nxt [0:2];
  logic [1:0] hcnt_r, hcnt_nxt;
  logic [2:0] ctrl_r;
  logic [31:0] motion_r;
  logic [31:0] mot_src;

  wire usb_sel   = ctrl_r[CTRL_USB_BIT];
  wire ps2_cap   = ctrl_r[CTRL_PS2_BIT];
  wire five_part = ctrl_r[CTRL_FIVE_BIT];

  wire seq_3d   = ps2_cap && hcnt_r == 2'd3 && hist_r[0] == RATE_A
                  && hist_r[1] == RATE_B && hist_r[2] == RATE_C;
  wire seq_five = ps2_cap && five_part && hcnt_r == 2'd3 && hist_r[0] == RATE_A
                  && hist_r[1] == RATE_A && hist_r[2] == RATE_C;

  // First status byte, buttons left, middle, right
  wire [7:0] stat1 = {1'b0, remote_r, enable_r, scale_r, wrap_r, btn[0], btn[1], btn[2]};

  // ************************************************************
  // Report building
  // ************************************************************
  wire [8:0] mx   = mot_src[MOT_X_LSB +: 9];
  wire [8:0] my   = mot_src[MOT_Y_LSB +: 9];
  wire       xovf = mot_src[MOT_XV_BIT];
  wire       yovf = mot_src[MOT_YV_BIT];
  wire signed [9:0] z8 = clamp(wscaled, 10'sd127);
  wire signed [9:0] z4 = clamp(wscaled, 10'sd7);
  wire signed [9:0] zused = (mode_r == MODE_FIVE) ? z4 : z8;
  wire [7:0] y_neg = 8'h00 - my[7:0];
  wire [7:0] z_neg = 8'h00 - z8[7:0];

  wire [7:0] ps2_b1 = {(mode_r == MODE_FIVE) ? 2'b00 : {yovf, xovf},
                       my[8], mx[8], 1'b1, btn[1], btn[2], btn[0]};
  wire [7:0] ps2_b4 = (mode_r == MODE_FIVE) ? {2'b00, btn[4], btn[3], z4[3:0]} : z8[7:0];
  wire [7:0] usb_b1 = five_part ? {3'b000, btn[4], btn[3], btn[1], btn[2], btn[0]}
                                : {5'b00000, btn[1], btn[2], btn[0]};
  wire [2:0] ps2_len = (mode_r == MODE_STD) ? 3'd3 : 3'd4;

  // ************************************************************
  // Transmit queue
  // ************************************************************
  logic [7:0] txq_r [0:TXQ_DEPTH-1];
  logic [2:0] txq_cnt_r;
  logic       ld;
  logic [2:0] ld_cnt;
  logic [7:0] ld_q [0:TXQ_DEPTH-1];
  logic       mot_wr, mot_ok;

  assign tx_valid = (txq_cnt_r != 3'd0);
  assign tx_byte  = txq_r[0];
  wire   q_idle   = ~tx_valid;
  wire   host_rpt = ~usb_sel & enable_r & ~remote_r & ~wrap_r;
  assign mot_ok   = q_idle & ~rx_stb_r & (usb_sel | host_rpt);

  // Command interpreter and report loader
  always_comb begin
    mode_nxt = mode_r;
    argw_nxt = ARG_NONE;
    remote_nxt = remote_r;
    enable_nxt = enable_r;
    scale_nxt = scale_r;
    wrap_nxt = wrap_r;
    res_nxt = res_r;
    rate_nxt = rate_r;
    hist_nxt = hist_r;
    hcnt_nxt = hcnt_r;
    ld = 1'b0;
    ld_cnt = 3'd1;
    for (int i = 0; i < TXQ_DEPTH; i++) ld_q[i] = 8'h00;
    ld_q[0] = ANS_ACK;
    if (rx_stb_r) begin
      ld = 1'b1;
      // Any byte other than F3 or a rate after F3 breaks the sequence
      if (argw_r != ARG_RATE && rx_byte != CMD_SET_RATE && rx_byte != CMD_IDENTIFY)
        hcnt_nxt = 2'd0;
      if (wrap_r && rx_byte != CMD_RESET && rx_byte != CMD_WRAP_EXIT) begin
        ld_q[0] = rx_byte;
        hcnt_nxt = 2'd0;
      end else if (argw_r == ARG_RATE) begin
        rate_nxt = rx_byte;
        hist_nxt[0] = hist_r[1];
        hist_nxt[1] = hist_r[2];
        hist_nxt[2] = rx_byte;
        hcnt_nxt = (hcnt_r == 2'd3) ? 2'd3 : hcnt_r + 2'd1;
      end else if (argw_r == ARG_RES) begin
        res_nxt = rx_byte;
      end else begin
        case (rx_byte)
          CMD_RESET: begin
            mode_nxt = MODE_STD;
            {remote_nxt, enable_nxt, scale_nxt, wrap_nxt} = 4'h0;
            res_nxt = RES_RESET;
            rate_nxt = RATE_RESET;
            hcnt_nxt = 2'd0;
            ld_cnt = 3'd3;
            ld_q[1] = ANS_PASSED;
            ld_q[2] = ID_STD;
          end
          CMD_DEFAULTS: begin
            {remote_nxt, enable_nxt, scale_nxt} = 3'h0;
            res_nxt = RES_RESET;
            rate_nxt = RATE_RESET;
          end
          CMD_DISABLE:   enable_nxt = 1'b0;
          CMD_ENABLE:    enable_nxt = 1'b1;
          CMD_SET_RATE:  argw_nxt = ARG_RATE;
          CMD_SET_RES:   argw_nxt = ARG_RES;
          CMD_REMOTE:    remote_nxt = 1'b1;
          CMD_STREAM:    remote_nxt = 1'b0;
          CMD_WRAP:      wrap_nxt = 1'b1;
          CMD_WRAP_EXIT: wrap_nxt = 1'b0;
          CMD_SCALE_2:   scale_nxt = 1'b1;
          CMD_SCALE_1:   scale_nxt = 1'b0;
          // Identify answers with the resulting mode
          CMD_IDENTIFY: begin
            ld_cnt = 3'd2;
            hcnt_nxt = 2'd0;
            if (seq_five) mode_nxt = MODE_FIVE;
            else if (seq_3d) mode_nxt = MODE_3D;
            ld_q[1] = seq_five ? ID_FIVE : seq_3d ? ID_3D
                    : (mode_r == MODE_FIVE) ? ID_FIVE : (mode_r == MODE_3D) ? ID_3D : ID_STD;
          end
          CMD_STATUS: begin
            ld_cnt = 3'd4;
            ld_q[1] = stat1;
            ld_q[2] = res_r;
            ld_q[3] = rate_r;
          end
          CMD_READ_DATA: begin
            ld_cnt = ps2_len + 3'd1;
            ld_q[1] = ps2_b1;
            ld_q[2] = mx[7:0];
            ld_q[3] = my[7:0];
            ld_q[4] = ps2_b4;
          end
          default: ld_q[0] = ANS_ERROR;
        endcase
      end
    end else if (mot_wr && mot_ok) begin
      ld = 1'b1;
      ld_cnt = usb_sel ? 3'd4 : ps2_len;
      ld_q[0] = usb_sel ? usb_b1 : ps2_b1;
      ld_q[1] = mx[7:0];
      ld_q[2] = usb_sel ? y_neg : my[7:0];
      ld_q[3] = usb_sel ? z_neg : ps2_b4;
    end
  end

  wire rpt_taken = ld && ((mot_wr && mot_ok) || (rx_stb_r && argw_r == ARG_NONE && !wrap_r
                                     && rx_byte == CMD_READ_DATA));

  // Settings registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= MODE_STD;
      argw_r <= ARG_NONE;
      {remote_r, enable_r, scale_r, wrap_r} <= 4'h0;
      res_r <= RES_RESET;
      rate_r <= RATE_RESET;
      hist_r <= '{8'h00, 8'h00, 8'h00};
      hcnt_r <= 2'd0;
    end else begin
      mode_r <= mode_nxt;
      argw_r <= rx_stb_r ? argw_nxt : argw_r;
      {remote_r, enable_r, scale_r, wrap_r} <= {remote_nxt, enable_nxt, scale_nxt, wrap_nxt};
      res_r <= res_nxt;
      rate_r <= rate_nxt;
      hist_r <= hist_nxt;
      hcnt_r <= hcnt_nxt;
    end
  end

  // Queue load or shift out, and wheel accumulation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txq_cnt_r <= 3'd0;
      for (int i = 0; i < TXQ_DEPTH; i++) txq_r[i] <= 8'h00;
      wacc_r <= 10'sd0;
    end else begin
      if (ld) begin
        txq_r <= ld_q;
        txq_cnt_r <= ld_cnt;
      end else if (tx_valid && tx_ready) begin
        for (int i = 0; i < TXQ_DEPTH - 1; i++) txq_r[i] <= txq_r[i+1];
        txq_r[TXQ_DEPTH-1] <= 8'h00;
        txq_cnt_r <= txq_cnt_r - 3'd1;
      end
      // Remove the reported share at the selected division
      wacc_r <= wacc_r + (ph_step ? (ph_up ? 10'sd1 : -10'sd1) : 10'sd0)
                - (rpt_taken ? (div4 ? (zused <<< 2) : (zused <<< 1)) : 10'sd0);
    end
  end

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  logic        aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [3:0]  awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r, rresp_r;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
  endfunction : merge

  wire        do_wr   = aw_got_r & w_got_r;
  wire        wr_ctrl = do_wr && awaddr_r == OFF_CTRL;
  assign      mot_wr  = do_wr && awaddr_r == OFF_MOTION;
  wire        wr_ok   = wr_ctrl | (mot_wr & mot_ok);
  wire [31:0] ctrl_merged = merge({29'h0, ctrl_r}, wdata_r, wstrb_r);
  // Motion word after this cycle's write, so a queued report carries the new values
  assign      mot_src = (mot_wr && mot_ok) ? merge(motion_r, wdata_r, wstrb_r) : motion_r;
  wire        rd_take = s_axi_arvalid & s_axi_arready;
  wire [31:0] status_w = {5'h00, ~q_idle, mode_r, rate_r, res_r, stat1};
  wire        rd_hit  = s_axi_araddr == OFF_CTRL || s_axi_araddr == OFF_MOTION
                        || s_axi_araddr == OFF_STATUS || s_axi_araddr == OFF_WHEEL;
  wire [31:0] rd_mux  = (s_axi_araddr == OFF_CTRL)   ? {29'h0, ctrl_r}
                      : (s_axi_araddr == OFF_MOTION) ? motion_r
                      : (s_axi_araddr == OFF_STATUS) ? status_w
                      : (s_axi_araddr == OFF_WHEEL)  ? {{22{wacc_r[9]}}, wacc_r} : 32'h0;

  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready  = ~w_got_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_got_r, w_got_r, bvalid_r} <= 3'h0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bresp_r <= 2'b00;
      ctrl_r <= CTRL_RESET;
      motion_r <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        {aw_got_r, w_got_r, bvalid_r} <= 3'b001;
        bresp_r <= wr_ok ? 2'b00 : 2'b10;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (wr_ctrl) ctrl_r <= ctrl_merged[2:0];
      if (mot_wr && mot_ok) motion_r <= mot_src;
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'b00;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? 2'b00 : 2'b10;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  wire cmd_now = rx_stb_r && argw_r == ARG_NONE && !wrap_r;

  a_reset_cmd_std:
    assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_now && rx_byte == CMD_RESET |=> mode_r == MODE_STD && txq_r[1] == ANS_PASSED)
    else $error("reset command did not restore standard mode");
  a_por_std_mode:
    assert property (@(posedge aclk) $rose(aresetn) |-> mode_r == MODE_STD)
    else $error("mode not standard after reset");
  a_enter_three_d:
    assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_now && rx_byte == CMD_IDENTIFY && seq_3d && !seq_five
      |=> mode_r == MODE_3D && txq_r[0] == ANS_ACK && txq_r[1] == ID_3D)
    else $error("3D sequence not honoured");
  a_enter_five_btn:
    assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_now && rx_byte == CMD_IDENTIFY && seq_five
      |=> mode_r == MODE_FIVE && txq_r[1] == ID_FIVE && txq_cnt_r == 3'd2)
    else $error("five-button sequence not honoured");
  a_status_bytes:
    assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_now && rx_byte == CMD_STATUS
      |=> txq_r[2] == $past(res_r) && txq_r[3] == $past(rate_r) && txq_r[1][7] == 1'b0)
    else $error("status bytes wrong");
  a_broken_seq:
    assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_now && rx_byte != CMD_SET_RATE && rx_byte != CMD_IDENTIFY && rx_byte != CMD_RESET
      |=> hcnt_r == 2'd0 && $stable(mode_r))
    else $error("partial sequence kept");
  a_ps2_const_bit:
    assert property (@(posedge aclk) disable iff (!aresetn)
      mot_wr && mot_ok && !usb_sel |=> txq_r[0][3] && txq_cnt_r == $past(ps2_len))
    else $error("PS/2 packet byte 1 or length wrong");
  a_usb_byte_one:
    assert property (@(posedge aclk) disable iff (!aresetn)
      mot_wr && mot_ok && usb_sel |=> txq_r[0][7:5] == 3'b000 && txq_cnt_r == 3'd4
      && txq_r[2] == $past(y_neg))
    else $error("USB report wrong");
  a_five_clear_ovf:
    assert property (@(posedge aclk) disable iff (!aresetn)
      mode_r == MODE_FIVE |-> ps2_b1[7:6] == 2'b00 && ps2_b4[7:6] == 2'b00)
    else $error("five-button byte layout wrong");

endmodule : mouse_report

// ### tb/mouse_report_tb.sv
module mouse_report_tb
  import mouse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awv, wv, awr, wr, bv, br, arv, arr, rv, rr;
  logic        txv, txr, pclk, pdat, wsel, wa, wb;
  logic [3:0]  awa, ara;
  logic [31:0] wd, rd, d;
  logic [1:0]  bresp, r, rresp;
  logic [7:0]  txb;
  logic [4:0]  btn;
  int          n_fail, comparisons;

  mouse_report DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .ps2_clk_in(pclk),
    .ps2_data_in(pdat), .tx_valid(txv), .tx_byte(txb), .tx_ready(txr),
    .btn_left(btn[0]), .btn_middle(btn[1]), .btn_right(btn[2]),
    .fourth_button(btn[3]), .fifth_button(btn[4]), .wheel_phase_a(wa),
    .wheel_phase_b(wb), .wheel_scale_select(wsel));
  ps2_host_model host (
    .aclk(aclk), .tx_valid(txv), .tx_byte(txb), .tx_ready(txr),
    .ps2_clk_in(pclk), .ps2_data_in(pdat));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Write: offer address and data together, release each when taken
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    awa <= a;
    wd  <= v;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wr;
      tb = bv;
      r  = bresp;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb);
    br <= 1'b0;
  endtask : axw

  task automatic axr(input logic [3:0] a);
    logic ta, t;
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arv && arr;
      t  = rv;
      d  = rd;
      r  = rresp;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
    end while (!t);
    rr <= 1'b0;
  endtask : axr

  // Compare collected answer bytes, first byte in the low lane
  task automatic expect_bytes(input int n, input logic [31:0] e);
    repeat (40) @(posedge aclk);
    chk("answer count", 32'(host.got.size()), 32'(n));
    for (int i = 0; i < n; i++) chk("answer byte", {24'h0, host.got[i]}, {24'h0, e[8*i+:8]});
    host.got.delete();
  endtask : expect_bytes

  task automatic cmd(input logic [7:0] b, input int n, input logic [31:0] e);
    host.send(b);
    expect_bytes(n, e);
  endtask : cmd

  task automatic rates(input logic [23:0] rs);
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_SET_RATE, 1, {24'h0, ANS_ACK});
      cmd(rs[8*i+:8], 1, {24'h0, ANS_ACK});
    end
  endtask : rates

  task automatic mode_is(input logic [1:0] m);
    axr(OFF_STATUS);
    chk("mode", {30'h0, d[STS_MODE_LSB+:2]}, {30'h0, m});
    chk("read resp", {30'h0, r}, 32'h0);
  endtask : mode_is

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    report_and_stop();
  end

  // Quadrature steps toward the user, one every four cycles
  task automatic wheel_steps(input int n);
    for (int i = 0; i < n; i++) begin
      if (wa == wb) wb <= ~wa;
      else wa <= wb;
      repeat (4) @(posedge aclk);
    end
  endtask : wheel_steps

  task automatic power_on_test;
    cmd(CMD_STATUS, 4, {RATE_RESET, RES_RESET, 8'h00, ANS_ACK});
    mode_is(2'd0);
    cmd(CMD_IDENTIFY, 2, {16'h0, ID_STD, ANS_ACK});
    $display("power-on test done");
  endtask : power_on_test

  task automatic wheel_mode_test;
    rates({RATE_C, RATE_B, RATE_A});
    cmd(CMD_IDENTIFY, 2, {16'h0, ID_3D, ANS_ACK});
    mode_is(2'd1);
    btn <= 5'b00101;
    cmd(CMD_STATUS, 4, {RATE_C, RES_RESET, 8'h05, ANS_ACK});
    cmd(CMD_RESET, 3, {8'h0, ID_STD, ANS_PASSED, ANS_ACK});
    mode_is(2'd0);
    $display("wheel mode test done");
  endtask : wheel_mode_test

  task automatic broken_seq_test;
    cmd(CMD_SET_RATE, 1, {24'h0, ANS_ACK});
    cmd(RATE_A, 1, {24'h0, ANS_ACK});
    cmd(CMD_ENABLE, 1, {24'h0, ANS_ACK});
    cmd(CMD_SET_RATE, 1, {24'h0, ANS_ACK});
    cmd(RATE_C, 1, {24'h0, ANS_ACK});
    cmd(CMD_IDENTIFY, 2, {16'h0, ID_STD, ANS_ACK});
    $display("broken sequence test done");
  endtask : broken_seq_test

  task automatic packet_test;
    axw(OFF_MOTION, {6'h0, 1'b0, 9'h005, 6'h0, 1'b0, 9'h1fd});
    chk("motion bresp", {30'h0, r}, 32'h0);
    expect_bytes(3, {8'h0, 8'h05, 8'hfd, 8'h1b});
    axw(OFF_STATUS, 32'h0);
    chk("status bresp", {30'h0, r}, 32'h2);
    $display("packet test done");
  endtask : packet_test

  task automatic five_button_test;
    host.slow = 1'b1;
    wsel <= 1'b1;
    rates({RATE_C, RATE_A, RATE_A});
    cmd(CMD_IDENTIFY, 2, {16'h0, ID_FIVE, ANS_ACK});
    mode_is(2'd2);
    btn <= 5'b11000;
    wheel_steps(8);
    axr(OFF_WHEEL);
    chk("wheel count", d, 32'h8);
    axw(OFF_MOTION, {6'h0, 1'b1, 9'h1fe, 6'h0, 1'b0, 9'h001});
    expect_bytes(4, {8'h32, 8'hfe, 8'h01, 8'h28});
    axr(OFF_WHEEL);
    chk("wheel left", d, 32'h0);
    axw(OFF_CTRL, 32'h7);
    wheel_steps(4);
    axw(OFF_MOTION, {6'h0, 1'b0, 9'h003, 6'h0, 1'b0, 9'h002});
    expect_bytes(4, {8'hff, 8'hfd, 8'h02, 8'h18});
    cmd(CMD_RESET, 3, {8'h0, ID_STD, ANS_PASSED, ANS_ACK});
    $display("five-button test done");
  endtask : five_button_test

  initial begin
    {aresetn, awv, wv, br, arv, rr, wsel, wa, wb, btn, awa, ara, wd} = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    power_on_test();
    wheel_mode_test();
    broken_seq_test();
    packet_test();
    five_button_test();
    report_and_stop();
  end
endmodule : mouse_report_tb

// ### tb/ps2_host_model.sv
// Host side of the link: sends framed command bytes and collects answers
module ps2_host_model (
  input  wire logic       aclk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready,
  output logic            ps2_clk_in,
  output logic            ps2_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic       slow;
  initial begin
    tx_ready    = 1'b1;
    ps2_clk_in  = 1'b1;
    ps2_data_in = 1'b1;
    slow        = 1'b0;
  end
  // Collect answer bytes while settled, ahead of the edge that pops them
  always @(negedge aclk) begin
    if (tx_valid && tx_ready) got.push_back(tx_byte);
  end
  // Stall every other cycle when slow
  always @(posedge aclk) begin
    tx_ready <= slow ? !tx_ready : 1'b1;
  end
  // Start, data LSB first, odd parity, stop; clock idles high between frames
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      ps2_data_in = f[i];
      #62.5 ps2_clk_in = 1'b0;
      #62.5 ps2_clk_in = 1'b1;
    end
    ps2_data_in = 1'b1;
  endtask : send
endmodule : ps2_host_model
